// *** overlay_pkg.sv ***
// constants and types for the sprite and cursor overlay
// =====================================================
`default_nettype none
package overlay_pkg;
  // =====================================================
  // register indices on the indexed port
  localparam logic [5:0] IDX_X_HI = 6'h30;
  localparam logic [5:0] IDX_X_LO = 6'h31;
  localparam logic [5:0] IDX_Y_HI = 6'h32;
  localparam logic [5:0] IDX_Y_LO = 6'h33;
  localparam logic [5:0] IDX_CLIP_COL = 6'h34;
  localparam logic [5:0] IDX_CLIP_ROW = 6'h35;
  localparam logic [5:0] IDX_ADDR_HI = 6'h36;
  localparam logic [5:0] IDX_ADDR_LO = 6'h37;
  localparam logic [5:0] IDX_FUNC = 6'h38;
  localparam logic [5:0] IDX_PAL0 = 6'h3c;
  localparam logic [5:0] IDX_PAL1 = 6'h3d;
  localparam logic [5:0] IDX_PAL2 = 6'h3e;
  localparam logic [5:0] IDX_PAL3 = 6'h3f;
  localparam logic [1:0] IDX_BANK = 2'h3;
  // =====================================================
  // function register fields and reset value
  localparam int unsigned FN_VDBL = 3;
  localparam int unsigned FN_HDBL = 2;
  localparam int unsigned FN_CURSOR = 1;
  localparam int unsigned FN_SCHEME = 0;
  localparam logic [7:0] REG_RESET = 8'h00;
  // =====================================================
  // pattern geometry
  localparam int unsigned PAT_ROWS = 64;
  localparam int unsigned PAT_COLS = 64;
  localparam logic [2:0] SPRITE_LAST_FETCH = 3'h7;
  localparam logic [2:0] CURSOR_LAST_FETCH = 3'h3;
  // =====================================================
  // types
  typedef struct packed {
    logic active;
    logic [9:0] x;
    logic [3:0] shade;
  } video_in_t;
  typedef enum logic {FS_IDLE, FS_FETCH} fetch_state_t;
endpackage : overlay_pkg
`default_nettype wire

// *** sprite_cursor_overlay.sv ***
// sprite and cursor overlay: registers, pattern fetch, pixel mix
`timescale 1ns/1ps
`default_nettype none
module sprite_cursor_overlay #(
  parameter int unsigned ROWS = 64
) (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic reg_index_wr,
  input wire logic reg_data_wr,
  input wire logic reg_data_rd,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  input wire logic overlay_enable,
  input wire logic line_start,
  input wire logic [8:0] line_y,
  input wire overlay_pkg::video_in_t video_in,
  output logic [3:0] pix_out,
  output logic pix_from_overlay,
  output logic fetch_req,
  output logic [17:0] video_mem_addr,
  input wire logic fetch_ack,
  input wire logic [31:0] fetch_data
);
  // =====================================================
  // elaboration check
  if (ROWS != overlay_pkg::PAT_ROWS) begin : g_bad_rows
    $error("pattern rows must be 64");
  end

  // =====================================================
  // register port
  logic [5:0] index_q;
  logic [7:0] regs_q [16];
  logic [7:0] rdata_q;

  // writable bits per index, zero for unmapped
  function automatic logic [7:0] reg_mask(input logic [5:0] idx);
    logic [7:0] m;
    m = 8'h00;
    if (idx == overlay_pkg::IDX_X_HI) begin
      m = 8'h03;
    end else if (idx == overlay_pkg::IDX_X_LO || idx == overlay_pkg::IDX_Y_LO) begin
      m = 8'hff;
    end else if (idx == overlay_pkg::IDX_ADDR_LO) begin
      m = 8'hff;
    end else if (idx == overlay_pkg::IDX_Y_HI || idx == overlay_pkg::IDX_ADDR_HI) begin
      m = 8'h01;
    end else if (idx == overlay_pkg::IDX_CLIP_COL || idx == overlay_pkg::IDX_CLIP_ROW) begin
      m = 8'h3f;
    end else if (idx == overlay_pkg::IDX_FUNC) begin
      m = 8'h0f;
    end else if (idx[5:2] == overlay_pkg::IDX_PAL0[5:2]) begin
      m = 8'h0f;
    end
    return m;
  endfunction : reg_mask

  // index latch
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      index_q <= 6'h00;
    end else if (reg_index_wr) begin
      index_q <= reg_wdata[5:0];
    end
  end

  // register writes, reserved bits dropped
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      for (int i = 0; i < 16; i++) begin
        regs_q[i] <= overlay_pkg::REG_RESET;
      end
    end else if (reg_data_wr && index_q[5:4] == overlay_pkg::IDX_BANK) begin
      regs_q[index_q[3:0]] <= reg_wdata & reg_mask(index_q);
    end
  end

  // read data, unmapped reads zero
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      rdata_q <= 8'h00;
    end else if (reg_data_rd) begin
      rdata_q <= (index_q[5:4] == overlay_pkg::IDX_BANK) ? (regs_q[index_q[3:0]] & reg_mask(index_q)) : 8'h00;
    end
  end
  assign reg_rdata = rdata_q;

  // =====================================================
  // decoded fields
  logic [9:0] x_pos;
  logic [8:0] y_pos;
  logic [5:0] clip_col;
  logic [5:0] clip_row;
  logic [8:0] pat_base;
  logic [7:0] func;
  logic vdbl, hdbl, cursor_sel, scheme_sel;
  logic [3:0] pal [4];

  assign x_pos = {regs_q[overlay_pkg::IDX_X_HI[3:0]][1:0], regs_q[overlay_pkg::IDX_X_LO[3:0]]};
  assign y_pos = {regs_q[overlay_pkg::IDX_Y_HI[3:0]][0], regs_q[overlay_pkg::IDX_Y_LO[3:0]]};
  assign clip_col = regs_q[overlay_pkg::IDX_CLIP_COL[3:0]][5:0];
  assign clip_row = regs_q[overlay_pkg::IDX_CLIP_ROW[3:0]][5:0];
  assign pat_base = {regs_q[overlay_pkg::IDX_ADDR_HI[3:0]][0], regs_q[overlay_pkg::IDX_ADDR_LO[3:0]]};
  assign func = regs_q[overlay_pkg::IDX_FUNC[3:0]];
  // mode bits count only while enabled
  assign vdbl = overlay_enable & func[overlay_pkg::FN_VDBL];
  assign hdbl = overlay_enable & func[overlay_pkg::FN_HDBL];
  assign cursor_sel = overlay_enable & func[overlay_pkg::FN_CURSOR];
  assign scheme_sel = overlay_enable & func[overlay_pkg::FN_SCHEME];
  // palette shades, entry 0 is also cursor background
  assign pal[0] = regs_q[overlay_pkg::IDX_PAL0[3:0]][3:0];
  assign pal[1] = regs_q[overlay_pkg::IDX_PAL1[3:0]][3:0];
  assign pal[2] = regs_q[overlay_pkg::IDX_PAL2[3:0]][3:0];
  assign pal[3] = regs_q[overlay_pkg::IDX_PAL3[3:0]][3:0];

  // =====================================================
  // row selection for the coming line
  logic [8:0] dy, row_off;
  logic [9:0] row_sum;
  logic row_vis;
  logic [5:0] line_row_q;
  logic line_vis_q;

  // origin stays at y_pos, doubling halves the offset
  assign dy = line_y - y_pos;
  assign row_off = vdbl ? {1'b0, dy[8:1]} : dy;
  assign row_sum = {4'h0, clip_row} + {1'b0, row_off};
  assign row_vis = overlay_enable && (line_y >= y_pos) && (row_sum < 10'(ROWS));

  // latch row per line
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      line_row_q <= 6'h00;
      line_vis_q <= 1'b0;
    end else if (line_start) begin
      line_row_q <= row_sum[5:0];
      line_vis_q <= row_vis;
    end
  end

  // =====================================================
  // pattern fetch
  overlay_pkg::fetch_state_t state_q;
  logic [2:0] fetch_idx_q;
  logic fetch_cursor_q;
  logic [2:0] fetch_last;

  assign fetch_last = fetch_cursor_q ? overlay_pkg::CURSOR_LAST_FETCH : overlay_pkg::SPRITE_LAST_FETCH;

  // one word per acknowledge until the row is loaded
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      state_q <= overlay_pkg::FS_IDLE;
      fetch_idx_q <= 3'h0;
      fetch_cursor_q <= 1'b0;
    end else begin
      case (state_q)
        overlay_pkg::FS_IDLE: begin
          if (line_start && row_vis) begin
            state_q <= overlay_pkg::FS_FETCH;
            fetch_idx_q <= 3'h0;
            fetch_cursor_q <= cursor_sel;
          end
        end
        overlay_pkg::FS_FETCH: begin
          if (fetch_ack) begin
            fetch_idx_q <= fetch_idx_q + 3'h1;
            if (fetch_idx_q == fetch_last) begin
              state_q <= overlay_pkg::FS_IDLE;
            end
          end
        end
        default: state_q <= overlay_pkg::FS_IDLE;
      endcase
    end
  end

  assign fetch_req = (state_q == overlay_pkg::FS_FETCH);
  assign video_mem_addr = {pat_base, line_row_q, fetch_idx_q};

  // =====================================================
  // row pattern buffer, two bits per column
  logic [1:0] pat_q [overlay_pkg::PAT_COLS];

  for (genvar j = 0; j < 64; j++) begin : g_pat
    localparam int SB0 = 7 - (j % 8);
    localparam int CB0 = ((j % 16) / 8) * 16 + 7 - (j % 8);
    // sprite: 8 pixels per word, cursor: 16 per word
    always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
        pat_q[j] <= 2'h0;
      end else if (fetch_req && fetch_ack) begin
        if (!fetch_cursor_q && fetch_idx_q == 3'(j / 8)) begin
          pat_q[j] <= {fetch_data[SB0 + 8], fetch_data[SB0]};
        end else if (fetch_cursor_q && fetch_idx_q == 3'(j / 16)) begin
          pat_q[j] <= {fetch_data[CB0 + 8], fetch_data[CB0]};
        end
      end
    end
  end

  // =====================================================
  // column selection and pixel mix
  logic [9:0] dx, col_off;
  logic [10:0] col_sum;
  logic vis;
  logic [1:0] code;
  logic [3:0] mix;
  logic mix_ovl;
  logic [3:0] pix_q;
  logic ovl_q;

  // origin stays at x_pos, doubling halves the offset
  assign dx = video_in.x - x_pos;
  assign col_off = hdbl ? {1'b0, dx[9:1]} : dx;
  assign col_sum = {5'h00, clip_col} + {1'b0, col_off};
  assign vis = overlay_enable && line_vis_q && video_in.active && (video_in.x >= x_pos)
    && (col_sum < 11'(overlay_pkg::PAT_COLS));
  assign code = pat_q[col_sum[5:0]];

  // cursor decode when cursor_sel is set, sprite palette decode otherwise
  always_comb begin
    mix = video_in.shade;
    mix_ovl = 1'b0;
    if (vis) begin
      if (cursor_sel) begin
        case (code)
          2'h0: mix = pal[0];
          2'h1: mix = pal[1];
          2'h2: mix = video_in.shade;
          default: mix = ~video_in.shade;
        endcase
        mix_ovl = (code != 2'h2);
      end else if (scheme_sel && code == 2'h0) begin
        mix = video_in.shade;
      end else begin
        mix = pal[code];
        mix_ovl = 1'b1;
      end
    end
  end

  // registered pixel output
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      pix_q <= 4'h0;
      ovl_q <= 1'b0;
    end else begin
      pix_q <= mix;
      ovl_q <= mix_ovl;
    end
  end
  assign pix_out = pix_q;
  assign pix_from_overlay = ovl_q;

  // =====================================================
  // checks
  addr_base_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    fetch_req |-> video_mem_addr[17:9] == pat_base) else $error("fetch base wrong");
  row_first_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    $rose(fetch_req) |-> video_mem_addr[2:0] == 3'h0 && video_mem_addr[8:3] == $past(row_sum[5:0]))
    else $error("fetch start wrong");
  sprite_count_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    fetch_req && fetch_ack && !fetch_cursor_q && video_mem_addr[2:0] == 3'h7 |=> !fetch_req)
    else $error("sprite fetch count wrong");
  disabled_pass_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    !overlay_enable |=> pix_out == $past(video_in.shade) && !pix_from_overlay)
    else $error("disabled overlay altered pixel");
  left_edge_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    video_in.x < x_pos |=> !pix_from_overlay) else $error("overlay left of origin");
  origin_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    overlay_enable && line_vis_q && video_in.active && video_in.x == x_pos && clip_col == 6'h00
    |-> vis) else $error("origin pixel hidden");
  palette_pick_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    vis && !cursor_sel && !scheme_sel |=> pix_out == $past(pal[code]))
    else $error("sprite palette wrong");
  transparent_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    vis && !cursor_sel && scheme_sel && code == 2'h0 |=> pix_out == $past(video_in.shade))
    else $error("transparency wrong");
  cursor_invert_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    vis && cursor_sel && code == 2'h3 |=> pix_out == ~$past(video_in.shade))
    else $error("cursor invert wrong");
  pal0_readback_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    reg_data_wr && !reg_index_wr && index_q == overlay_pkg::IDX_PAL0 ##1 reg_data_rd && !reg_index_wr
    |=> reg_rdata == ($past(reg_wdata, 2) & 8'h0f)) else $error("entry zero readback wrong");
endmodule : sprite_cursor_overlay
`default_nettype wire

// *** tb_top.sv ***
// self-checking testbench for the sprite and cursor overlay
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  // =====================================================
  // clock, reset and design ports
  logic ref_clk;
  logic resetn;
  logic reg_index_wr, reg_data_wr, reg_data_rd, overlay_enable, line_start, fetch_ack;
  logic [7:0] reg_wdata;
  logic [7:0] reg_rdata;
  logic [8:0] line_y;
  overlay_pkg::video_in_t video_in;
  logic [3:0] pix_out;
  logic pix_from_overlay, fetch_req;
  logic [17:0] video_mem_addr;
  logic [31:0] fetch_data;
  int num_errors;
  int tests_run;
  // pixel 0 code 1, pixel 1 code 2, pixel 2 code 3, pixel 3 code 0; byte 2 only feeds cursor pixel 8
  localparam logic [31:0] WORD0 = 32'h0080_60a0;
  localparam logic [8:0] BASE = 9'h1ab;
  localparam logic [5:0] IDX [10] = '{overlay_pkg::IDX_X_HI, overlay_pkg::IDX_X_LO, overlay_pkg::IDX_Y_HI,
    overlay_pkg::IDX_Y_LO, overlay_pkg::IDX_CLIP_COL, overlay_pkg::IDX_CLIP_ROW, overlay_pkg::IDX_ADDR_HI,
    overlay_pkg::IDX_ADDR_LO, overlay_pkg::IDX_FUNC, overlay_pkg::IDX_PAL0};
  localparam logic [7:0] MASK [10] = '{8'h03, 8'hff, 8'h01, 8'hff, 8'h3f, 8'h3f, 8'h01, 8'hff, 8'h0f, 8'h0f};

  sprite_cursor_overlay #(.ROWS(64)) i_sprite_cursor_overlay (.ref_clk(ref_clk), .resetn(resetn),
    .reg_index_wr(reg_index_wr), .reg_data_wr(reg_data_wr), .reg_data_rd(reg_data_rd), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .overlay_enable(overlay_enable), .line_start(line_start), .line_y(line_y),
    .video_in(video_in), .pix_out(pix_out), .pix_from_overlay(pix_from_overlay), .fetch_req(fetch_req),
    .video_mem_addr(video_mem_addr), .fetch_ack(fetch_ack), .fetch_data(fetch_data));

  // =====================================================
  // clock and watchdog
  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end
  initial begin
    repeat (20000) @(posedge ref_clk);
    num_errors++;
    results();
  end

  // =====================================================
  // helper tasks
  task automatic step();
    @(posedge ref_clk);
    #1;
  endtask : step
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask : check
  task automatic reg_wr(input logic [5:0] idx, input logic [7:0] data);
    reg_index_wr = 1'b1;
    reg_wdata = {2'h0, idx};
    step();
    reg_index_wr = 1'b0;
    reg_data_wr = 1'b1;
    reg_wdata = data;
    step();
    reg_data_wr = 1'b0;
  endtask : reg_wr
  task automatic reg_rd(input logic [5:0] idx, input logic [7:0] exp);
    reg_index_wr = 1'b1;
    reg_wdata = {2'h0, idx};
    step();
    reg_index_wr = 1'b0;
    reg_data_rd = 1'b1;
    step();
    reg_data_rd = 1'b0;
    step();
    check(reg_rdata, exp);
  endtask : reg_rd
  // one line fetch, acking every column back to back
  task automatic fetch_line(input logic [8:0] line, input logic [5:0] row, input int cols);
    int n;
    line_y = line;
    line_start = 1'b1;
    step();
    line_start = 1'b0;
    for (int c = 0; c < cols; c++) begin
      n = 0;
      while (fetch_req !== 1'b1 && n < 20) begin
        step();
        n++;
      end
      check(video_mem_addr, {BASE, row, c[2:0]});
      fetch_ack = 1'b1;
      fetch_data = (c == 0) ? WORD0 : 32'h0;
      step();
    end
    fetch_ack = 1'b0;
    fetch_data = 32'hffff_ffff;
    check(fetch_req, 1'b0);
  endtask : fetch_line
  task automatic no_fetch(input logic [8:0] line);
    line_y = line;
    line_start = 1'b1;
    step();
    line_start = 1'b0;
    repeat (3) begin
      step();
      check(fetch_req, 1'b0);
    end
  endtask : no_fetch
  // screen shade is 3 on every pixel
  task automatic pix(input logic [9:0] x, input logic [3:0] exp, input logic ov);
    video_in = {1'b1, x, 4'h3};
    step();
    check(pix_out, exp);
    check(pix_from_overlay, ov);
  endtask : pix
  task automatic results();
    $display("errors %0d checks %0d", num_errors, tests_run);
    if (num_errors == 0 && tests_run > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : results

  // =====================================================
  // main sequence
  initial begin
    num_errors = 0;
    tests_run = 0;
    resetn = 1'b0;
    {reg_index_wr, reg_data_wr, reg_data_rd, overlay_enable, line_start, fetch_ack} = 6'h00;
    reg_wdata = 8'h00;
    line_y = 9'h000;
    video_in = '0;
    fetch_data = 32'h0;
    repeat (4) @(posedge ref_clk);
    #1;
    resetn = 1'b1;
    step();
    for (int i = 0; i < 10; i++) reg_rd(IDX[i], overlay_pkg::REG_RESET);
    for (int i = 0; i < 10; i++) reg_wr(IDX[i], 8'hff);
    for (int i = 0; i < 10; i++) reg_rd(IDX[i], MASK[i]);
    reg_rd(6'h39, 8'h00);
    // position 356,10; base 0x1ab; clip row 3; palettes 5,9,a,e
    reg_wr(overlay_pkg::IDX_X_HI, 8'h01);
    reg_wr(overlay_pkg::IDX_X_LO, 8'h64);
    reg_wr(overlay_pkg::IDX_Y_HI, 8'h00);
    reg_wr(overlay_pkg::IDX_Y_LO, 8'h0a);
    reg_wr(overlay_pkg::IDX_CLIP_COL, 8'h00);
    reg_wr(overlay_pkg::IDX_CLIP_ROW, 8'h03);
    reg_wr(overlay_pkg::IDX_ADDR_LO, 8'hab);
    reg_wr(overlay_pkg::IDX_FUNC, 8'h00);
    reg_wr(overlay_pkg::IDX_PAL0, 8'h05);
    // data write then read on the held index, no index cycle between
    reg_data_wr = 1'b1;
    reg_wdata = 8'ha5;
    step();
    reg_data_wr = 1'b0;
    reg_data_rd = 1'b1;
    step();
    reg_data_rd = 1'b0;
    check(reg_rdata, 32'h0000_0005);
    reg_wr(overlay_pkg::IDX_PAL1, 8'h09);
    reg_wr(overlay_pkg::IDX_PAL2, 8'h0a);
    reg_wr(overlay_pkg::IDX_PAL3, 8'h0e);
    overlay_enable = 1'b1;
    fetch_line(9'd10, 6'd3, 8);
    pix(10'd355, 4'h3, 1'b0);
    pix(10'd356, 4'h9, 1'b1);
    pix(10'd357, 4'ha, 1'b1);
    pix(10'd358, 4'he, 1'b1);
    pix(10'd359, 4'h5, 1'b1);
    pix(10'd419, 4'h5, 1'b1);
    pix(10'd420, 4'h3, 1'b0);
    reg_wr(overlay_pkg::IDX_CLIP_COL, 8'h02);
    pix(10'd356, 4'he, 1'b1);
    pix(10'd418, 4'h3, 1'b0);
    reg_wr(overlay_pkg::IDX_CLIP_COL, 8'h00);
    reg_wr(overlay_pkg::IDX_FUNC, 8'h01);
    pix(10'd359, 4'h3, 1'b0);
    pix(10'd356, 4'h9, 1'b1);
    reg_wr(overlay_pkg::IDX_FUNC, 8'h04);
    pix(10'd356, 4'h9, 1'b1);
    pix(10'd357, 4'h9, 1'b1);
    pix(10'd358, 4'ha, 1'b1);
    overlay_enable = 1'b0;
    pix(10'd356, 4'h3, 1'b0);
    pix(10'd358, 4'h3, 1'b0);
    no_fetch(9'd10);
    overlay_enable = 1'b1;
    reg_wr(overlay_pkg::IDX_CLIP_ROW, 8'h00);
    reg_wr(overlay_pkg::IDX_FUNC, 8'h08);
    fetch_line(9'd14, 6'd2, 8);
    reg_wr(overlay_pkg::IDX_FUNC, 8'h00);
    no_fetch(9'd9);
    no_fetch(9'd74);
    reg_wr(overlay_pkg::IDX_FUNC, 8'h02);
    fetch_line(9'd10, 6'd0, 4);
    pix(10'd356, 4'h9, 1'b1);
    pix(10'd357, 4'h3, 1'b0);
    pix(10'd358, 4'hc, 1'b1);
    pix(10'd359, 4'h5, 1'b1);
    pix(10'd364, 4'h9, 1'b1);
    results();
  end
endmodule : tb_top
`default_nettype wire
